// [pad_resistor_control_regs.sv]
// Pad pullup/pulldown control registers written by the embedded microcontroller
//
// How it works
// - Functional bit 0 selects INTRQ pullup when 1, pulldown when 0; resets 0.
// - Functional bit 1 set turns both INTRQ resistors off; clear enables selected one.
// - Functional bit 2 selects IORDY pullup when 1, pulldown when 0; resets 0.
// - Functional bit 3 set turns both IORDY resistors off; clear enables selected one.
// - Functional bit 4 set disconnects DMARQ pulldown; clear connects it; resets connected.
// - Functional bit 5 set disconnects data bus pulldowns except DD7; clear connects.
// - Functional bit 6 set disconnects VBUS pulldown; clear connects; resets connected.
// - Functional bit 7 controls DD7 pulldown alone; set disconnects; resets connected.
// - Each ATA select bit 0 to 6: 1 enables pullup only, 0 enables pulldown only.
// - Select bits map CS0, CS1, DA lines, DMACK, DIOR, DIOW, ATA reset.
// - ATA select bit 7 is reserved, read-only and reads 0.
// - Setting the ATA hard-reset bit clears select bit 6 to pulldown.
// - After power-up every ATA output pin has pulldown on, pullup off.
// - Power-down bit 1 disables both resistors; 0 enables the selected one.
`timescale 1ns/1ps

module pad_resistor_control_regs
	import pad_resistor_pkg::*;
(
	input  wire logic                    ref_clk,
	input  wire logic                    rst,
	input  wire logic                    clk_en,
	input  wire external_data_space_req_s              external_data_space_req,
	output logic [7:0]                   external_data_space_rdata,
	input  wire logic                    ata_hard_reset_request,
	input  wire logic [ATA_OUT_PINS-1:0] ata_output_resistor_powerdown,
	output pad_res_s                     intrq_res,
	output pad_res_s                     iordy_res,
	output logic                         dmarq_pd_en,
	output logic                         data_bus_pd_en,
	output logic                         vbus_pd_en,
	output logic                         data_bit7_pd_en,
	output ata_out_res_s                 ata_out_res
);

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	logic                    func_hit;
	logic                    sel_hit;
	logic [7:0]              func_cfg_q;
	logic [7:0]              ata_sel_q;
	logic [7:0]              ata_sel_d;
	logic [ATA_OUT_PINS-1:0] wdata_pins;

	assign func_hit   = external_data_space_req.addr == FUNC_CFG_ADDR;
	assign sel_hit    = external_data_space_req.addr == ATA_SEL_ADDR;
	assign wdata_pins = external_data_space_req.wdata[ATA_OUT_PINS-1:0];

	// ---------------------------------------------------------------
	// Functional pin register
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			func_cfg_q <= FUNC_CFG_RST;
		end else if (clk_en && external_data_space_req.wr && func_hit) begin
			func_cfg_q <= external_data_space_req.wdata;
		end
	end

	// ---------------------------------------------------------------
	// ATA output select register
	// ---------------------------------------------------------------
	// Hard reset beats a same-cycle write so the reset line never floats high
	always_comb begin
		ata_sel_d = ata_sel_q;
		if (external_data_space_req.wr && sel_hit) begin
			ata_sel_d = external_data_space_req.wdata & ATA_SEL_WMASK;
		end
		if (ata_hard_reset_request) begin
			ata_sel_d[ATA_RESET_SEL_BIT] = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ata_sel_q <= ATA_SEL_RST;
		end else if (clk_en) begin
			ata_sel_q <= ata_sel_d;
		end
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			external_data_space_rdata <= UNMAPPED_RDATA;
		end else if (clk_en && external_data_space_req.rd) begin
			if (func_hit) begin
				external_data_space_rdata <= func_cfg_q;
			end else if (sel_hit) begin
				external_data_space_rdata <= ata_sel_q & ATA_SEL_WMASK;
			end else begin
				external_data_space_rdata <= UNMAPPED_RDATA;
			end
		end
	end

	// ---------------------------------------------------------------
	// Selectable functional pads
	// ---------------------------------------------------------------
	// Registered so pad controls never glitch while a write lands
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			intrq_res <= '{pu_en: 1'b0, pd_en: 1'b1};
			iordy_res <= '{pu_en: 1'b0, pd_en: 1'b1};
		end else if (clk_en) begin
			intrq_res.pu_en <= ~func_cfg_q[INTRQ_OFF_BIT] & func_cfg_q[INTRQ_PU_SEL_BIT];
			intrq_res.pd_en <= ~func_cfg_q[INTRQ_OFF_BIT] & ~func_cfg_q[INTRQ_PU_SEL_BIT];
			iordy_res.pu_en <= ~func_cfg_q[IORDY_OFF_BIT] & func_cfg_q[IORDY_PU_SEL_BIT];
			iordy_res.pd_en <= ~func_cfg_q[IORDY_OFF_BIT] & ~func_cfg_q[IORDY_PU_SEL_BIT];
		end
	end

	// ---------------------------------------------------------------
	// Pulldown-only pads
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dmarq_pd_en     <= 1'b1;
			data_bus_pd_en  <= 1'b1;
			vbus_pd_en      <= 1'b1;
			data_bit7_pd_en <= 1'b1;
		end else if (clk_en) begin
			dmarq_pd_en     <= ~func_cfg_q[DMARQ_PD_OFF_BIT];
			data_bus_pd_en  <= ~func_cfg_q[DATA_PD_OFF_BIT];
			vbus_pd_en      <= ~func_cfg_q[VBUS_PD_OFF_BIT];
			data_bit7_pd_en <= ~func_cfg_q[DD7_PD_OFF_BIT];
		end
	end

	// ---------------------------------------------------------------
	// ATA output pads
	// ---------------------------------------------------------------
	// Index order CS0, CS1, DA lines (one bit), DMACK, DIOR, DIOW, reset output
	for (genvar i = 0; i < ATA_OUT_PINS; i++) begin : g_ata_pad
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				ata_out_res.pu_en[i] <= 1'b0;
				ata_out_res.pd_en[i] <= 1'b1;
			end else if (clk_en) begin
				ata_out_res.pu_en[i] <= ~ata_output_resistor_powerdown[i] & ata_sel_q[i];
				ata_out_res.pd_en[i] <= ~ata_output_resistor_powerdown[i] & ~ata_sel_q[i];
			end
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence s_func_wr(logic [7:0] mask, logic [7:0] val);
		clk_en && external_data_space_req.wr && func_hit && ((external_data_space_req.wdata & mask) == val) ##1 clk_en;
	endsequence

	sequence s_sel_wr;
		clk_en && external_data_space_req.wr && sel_hit && !ata_hard_reset_request
			##1 clk_en && !ata_hard_reset_request
			&& (ata_output_resistor_powerdown == ATA_NO_PINS);
	endsequence

	property p_intrq_pullup;
		@(posedge ref_clk) disable iff (rst)
		s_func_wr(8'h03, 8'h01) |=> intrq_res.pu_en && !intrq_res.pd_en;
	endproperty
	a_intrq_pullup: assert property (p_intrq_pullup) else $error("INTRQ pullup not selected");

	property p_intrq_off;
		@(posedge ref_clk) disable iff (rst)
		s_func_wr(8'h02, 8'h02) |=> !intrq_res.pu_en && !intrq_res.pd_en;
	endproperty
	a_intrq_off: assert property (p_intrq_off) else $error("INTRQ resistors not off");

	property p_iordy_pulldown;
		@(posedge ref_clk) disable iff (rst)
		s_func_wr(8'h0C, 8'h00) |=> !iordy_res.pu_en && iordy_res.pd_en;
	endproperty
	a_iordy_pulldown: assert property (p_iordy_pulldown) else $error("IORDY pulldown not selected");

	property p_iordy_off;
		@(posedge ref_clk) disable iff (rst)
		s_func_wr(8'h08, 8'h08) |=> !iordy_res.pu_en && !iordy_res.pd_en;
	endproperty
	a_iordy_off: assert property (p_iordy_off) else $error("IORDY resistors not off");

	property p_dmarq_off;
		@(posedge ref_clk) disable iff (rst)
		s_func_wr(8'h10, 8'h10) |=> !dmarq_pd_en;
	endproperty
	a_dmarq_off: assert property (p_dmarq_off) else $error("DMARQ pulldown still on");

	property p_data_bus_on;
		@(posedge ref_clk) disable iff (rst)
		s_func_wr(8'h20, 8'h00) |=> data_bus_pd_en;
	endproperty
	a_data_bus_on: assert property (p_data_bus_on) else $error("Data bus pulldown not on");

	property p_vbus_off;
		@(posedge ref_clk) disable iff (rst)
		s_func_wr(8'h40, 8'h40) |=> !vbus_pd_en;
	endproperty
	a_vbus_off: assert property (p_vbus_off) else $error("VBUS pulldown still on");

	property p_dd7_on;
		@(posedge ref_clk) disable iff (rst)
		s_func_wr(8'h80, 8'h00) |=> data_bit7_pd_en;
	endproperty
	a_dd7_on: assert property (p_dd7_on) else $error("DD7 pulldown not on");

	property p_ata_select;
		@(posedge ref_clk) disable iff (rst)
		s_sel_wr |=> (ata_out_res.pu_en == $past(wdata_pins, 2))
			&& (ata_out_res.pd_en == ~$past(wdata_pins, 2));
	endproperty
	a_ata_select: assert property (p_ata_select) else $error("ATA select not applied");

	property p_sel_rsv_zero;
		@(posedge ref_clk) disable iff (rst)
		clk_en && external_data_space_req.rd && sel_hit |=> !external_data_space_rdata[ATA_SEL_RSV_BIT];
	endproperty
	a_sel_rsv_zero: assert property (p_sel_rsv_zero) else $error("Reserved bit reads 1");

	property p_hard_reset;
		@(posedge ref_clk) disable iff (rst)
		clk_en && ata_hard_reset_request ##1 clk_en |=> !ata_out_res.pu_en[ATA_RESET_SEL_BIT];
	endproperty
	a_hard_reset: assert property (p_hard_reset) else $error("Reset pin pullup survived");

	property p_powerup;
		@(posedge ref_clk) disable iff (rst)
		$past(rst) |-> (ata_out_res.pd_en == ATA_ALL_PINS) && (ata_out_res.pu_en == ATA_NO_PINS);
	endproperty
	a_powerup: assert property (p_powerup) else $error("ATA pulldowns not on at power-up");

	property p_powerdown;
		@(posedge ref_clk) disable iff (rst)
		clk_en && ata_output_resistor_powerdown[CS0_SEL_BIT]
			|=> !ata_out_res.pu_en[CS0_SEL_BIT] && !ata_out_res.pd_en[CS0_SEL_BIT];
	endproperty
	a_powerdown: assert property (p_powerdown) else $error("Powered-down pin has resistor");

	property p_intrq_pulldown;
		@(posedge ref_clk) disable iff (rst)
		s_func_wr(8'h03, 8'h00) |=> !intrq_res.pu_en && intrq_res.pd_en;
	endproperty
	a_intrq_pulldown: assert property (p_intrq_pulldown) else $error("INTRQ pulldown not selected");

	property p_iordy_pullup;
		@(posedge ref_clk) disable iff (rst)
		s_func_wr(8'h0C, 8'h04) |=> iordy_res.pu_en && !iordy_res.pd_en;
	endproperty
	a_iordy_pullup: assert property (p_iordy_pullup) else $error("IORDY pullup not selected");

	property p_dmarq_on;
		@(posedge ref_clk) disable iff (rst)
		s_func_wr(8'h10, 8'h00) |=> dmarq_pd_en;
	endproperty
	a_dmarq_on: assert property (p_dmarq_on) else $error("DMARQ pulldown not on");

	property p_data_bus_off;
		@(posedge ref_clk) disable iff (rst)
		s_func_wr(8'h20, 8'h20) |=> !data_bus_pd_en;
	endproperty
	a_data_bus_off: assert property (p_data_bus_off) else $error("Data bus pulldown still on");

	property p_vbus_on;
		@(posedge ref_clk) disable iff (rst)
		s_func_wr(8'h40, 8'h00) |=> vbus_pd_en;
	endproperty
	a_vbus_on: assert property (p_vbus_on) else $error("VBUS pulldown not on");

	property p_dd7_off;
		@(posedge ref_clk) disable iff (rst)
		s_func_wr(8'h80, 8'h80) |=> !data_bit7_pd_en;
	endproperty
	a_dd7_off: assert property (p_dd7_off) else $error("DD7 pulldown still on");

	// Checked every enabled edge, so a late write or power-down change is covered too
	property p_ata_follow;
		@(posedge ref_clk) disable iff (rst)
		clk_en |=> (ata_out_res.pu_en ==
			($past(ata_sel_q[ATA_OUT_PINS-1:0]) & ~$past(ata_output_resistor_powerdown)))
			&& (ata_out_res.pd_en ==
			(~$past(ata_sel_q[ATA_OUT_PINS-1:0]) & ~$past(ata_output_resistor_powerdown)));
	endproperty
	a_ata_follow: assert property (p_ata_follow) else $error("ATA pad enables wrong");

	property p_reset_sel_clear;
		@(posedge ref_clk) disable iff (rst)
		clk_en && ata_hard_reset_request |=> !ata_sel_q[ATA_RESET_SEL_BIT];
	endproperty
	a_reset_sel_clear: assert property (p_reset_sel_clear) else $error("Reset select bit kept");

	property p_powerdown_all;
		@(posedge ref_clk) disable iff (rst)
		clk_en |=> ((ata_out_res.pu_en | ata_out_res.pd_en)
			& $past(ata_output_resistor_powerdown)) == ATA_NO_PINS;
	endproperty
	a_powerdown_all: assert property (p_powerdown_all) else $error("Powered-down pins not off");

	property p_func_powerup;
		@(posedge ref_clk) disable iff (rst)
		$past(rst) |-> !intrq_res.pu_en && intrq_res.pd_en
			&& !iordy_res.pu_en && iordy_res.pd_en
			&& dmarq_pd_en && data_bus_pd_en && vbus_pd_en && data_bit7_pd_en;
	endproperty
	a_func_powerup: assert property (p_func_powerup) else $error("Pad power-up state wrong");

endmodule : pad_resistor_control_regs

// [pad_resistor_pkg.sv]
// Constants and carrier types for the pad resistor control register bank
package pad_resistor_pkg;

	// ---------------------------------------------------------------
	// Register map in the external data space
	// ---------------------------------------------------------------
	localparam logic [15:0] FUNC_CFG_ADDR   = 16'hF08E;
	localparam logic [15:0] ATA_SEL_ADDR    = 16'hF08F;
	localparam logic [7:0]  FUNC_CFG_RST    = 8'h00;
	localparam logic [7:0]  ATA_SEL_RST     = 8'h00;
	localparam logic [7:0]  ATA_SEL_WMASK   = 8'h7F;
	localparam logic [7:0]  UNMAPPED_RDATA  = 8'h00;

	// ---------------------------------------------------------------
	// Functional pin register fields
	// ---------------------------------------------------------------
	localparam int INTRQ_PU_SEL_BIT   = 0;
	localparam int INTRQ_OFF_BIT      = 1;
	localparam int IORDY_PU_SEL_BIT   = 2;
	localparam int IORDY_OFF_BIT      = 3;
	localparam int DMARQ_PD_OFF_BIT   = 4;
	localparam int DATA_PD_OFF_BIT    = 5;
	localparam int VBUS_PD_OFF_BIT    = 6;
	localparam int DD7_PD_OFF_BIT     = 7;

	// ---------------------------------------------------------------
	// ATA output select register fields
	// ---------------------------------------------------------------
	localparam int ATA_OUT_PINS       = 7;
	localparam int CS0_SEL_BIT        = 0;
	localparam int CS1_SEL_BIT        = 1;
	localparam int DEV_ADDR_SEL_BIT   = 2;
	localparam int DMACK_SEL_BIT      = 3;
	localparam int DIOR_SEL_BIT       = 4;
	localparam int DIOW_SEL_BIT       = 5;
	localparam int ATA_RESET_SEL_BIT  = 6;
	localparam int ATA_SEL_RSV_BIT    = 7;
	localparam logic [ATA_OUT_PINS-1:0] ATA_ALL_PINS = 7'h7F;
	localparam logic [ATA_OUT_PINS-1:0] ATA_NO_PINS  = 7'h00;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} external_data_space_req_s;

	typedef struct packed {
		logic pu_en;
		logic pd_en;
	} pad_res_s;

	typedef struct packed {
		logic [ATA_OUT_PINS-1:0] pu_en;
		logic [ATA_OUT_PINS-1:0] pd_en;
	} ata_out_res_s;

endpackage : pad_resistor_pkg

// [pad_resistor_control_regs_tb_top.sv]
// Self-checking testbench for the pad resistor control register bank
`timescale 1ns/1ps

module pad_resistor_control_regs_tb_top;
	import pad_resistor_pkg::*;

	// ----------------------------------------------------------
	// Signals and design
	// ----------------------------------------------------------
	logic                    ref_clk;
	logic                    rst;
	logic                    clk_en;
	logic                    ata_hard_reset_request;
	external_data_space_req_s              external_data_space_req;
	logic [7:0]              external_data_space_rdata;
	logic [ATA_OUT_PINS-1:0] ata_output_resistor_powerdown;
	pad_res_s                intrq_res;
	pad_res_s                iordy_res;
	logic                    dmarq_pd_en;
	logic                    data_bus_pd_en;
	logic                    vbus_pd_en;
	logic                    data_bit7_pd_en;
	ata_out_res_s            ata_out_res;
	logic [7:0]              func_obs;
	logic [7:0]              rdv;
	logic [7:0]              ftab [10];
	int                      n_errors;
	int                      n_compared;

	assign func_obs = {intrq_res, iordy_res, dmarq_pd_en, data_bus_pd_en, vbus_pd_en,
		data_bit7_pd_en};

	pad_resistor_control_regs pad_resistor_control_regs_i (
		.ref_clk                       (ref_clk),
		.rst                           (rst),
		.clk_en                        (clk_en),
		.external_data_space_req                     (external_data_space_req),
		.external_data_space_rdata                   (external_data_space_rdata),
		.ata_hard_reset_request        (ata_hard_reset_request),
		.ata_output_resistor_powerdown (ata_output_resistor_powerdown),
		.intrq_res                     (intrq_res),
		.iordy_res                     (iordy_res),
		.dmarq_pd_en                   (dmarq_pd_en),
		.data_bus_pd_en                (data_bus_pd_en),
		.vbus_pd_en                    (vbus_pd_en),
		.data_bit7_pd_en               (data_bit7_pd_en),
		.ata_out_res                   (ata_out_res)
	);

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------
	// Access tasks and expectations
	// ----------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk

	// Extra trailing edge lets the pad output flop catch up
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		external_data_space_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(negedge ref_clk);
		external_data_space_req.wr = 1'b0;
		@(negedge ref_clk);
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		external_data_space_req.addr = a;
		external_data_space_req.rd = 1'b1;
		@(negedge ref_clk);
		external_data_space_req.rd = 1'b0;
		d = external_data_space_rdata;
	endtask : rd

	function automatic logic [7:0] fexp(input logic [7:0] v);
		return {~v[1] & v[0], ~v[1] & ~v[0], ~v[3] & v[2], ~v[3] & ~v[2], ~v[4], ~v[5],
			~v[6], ~v[7]};
	endfunction : fexp

	function automatic logic [13:0] aexp(input logic [6:0] s, input logic [6:0] p);
		return {~p & s, ~p & ~s};
	endfunction : aexp

	task automatic check_reset();
		chk(func_obs, fexp(FUNC_CFG_RST));
		chk(ata_out_res, aexp(7'h00, 7'h00));
		rd(FUNC_CFG_ADDR, rdv);
		chk(rdv, FUNC_CFG_RST);
		rd(ATA_SEL_ADDR, rdv);
		chk(rdv, ATA_SEL_RST);
	endtask : check_reset

	task automatic close_out();
		$display("Compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out

	// ----------------------------------------------------------
	// Tests
	// ----------------------------------------------------------
	initial begin
		n_errors = 0;
		n_compared = 0;
		rst = 1'b1;
		clk_en = 1'b1;
		ata_hard_reset_request = 1'b0;
		ata_output_resistor_powerdown = '0;
		external_data_space_req = '0;
		ftab = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h05, 8'hFF};
		repeat (6) @(negedge ref_clk);
		rst = 1'b0;
		@(negedge ref_clk);
		check_reset();
		$display("Test reset values done");
		foreach (ftab[i]) begin
			wr(FUNC_CFG_ADDR, ftab[i]);
			chk(func_obs, fexp(ftab[i]));
			rd(FUNC_CFG_ADDR, rdv);
			chk(rdv, ftab[i]);
		end
		$display("Test functional pins done");
		for (int i = 0; i < 8; i++) begin
			wr(ATA_SEL_ADDR, 8'h01 << i);
			chk(ata_out_res, aexp(7'(8'h01 << i), 7'h00));
			rd(ATA_SEL_ADDR, rdv);
			chk(rdv, (8'h01 << i) & 8'h7F);
		end
		wr(ATA_SEL_ADDR, 8'h33);
		ata_output_resistor_powerdown = 7'h55;
		repeat (2) @(negedge ref_clk);
		chk(ata_out_res, aexp(7'h33, 7'h55));
		ata_output_resistor_powerdown = 7'h00;
		repeat (2) @(negedge ref_clk);
		chk(ata_out_res, aexp(7'h33, 7'h00));
		$display("Test output select done");
		wr(ATA_SEL_ADDR, 8'hFF);
		ata_hard_reset_request = 1'b1;
		@(negedge ref_clk);
		ata_hard_reset_request = 1'b0;
		repeat (2) @(negedge ref_clk);
		chk(ata_out_res, aexp(7'h3F, 7'h00));
		wr(ATA_SEL_ADDR, 8'h00);
		external_data_space_req = '{addr: ATA_SEL_ADDR, wdata: 8'hFF, wr: 1'b1, rd: 1'b0};
		ata_hard_reset_request = 1'b1;
		@(negedge ref_clk);
		external_data_space_req.wr = 1'b0;
		ata_hard_reset_request = 1'b0;
		rd(ATA_SEL_ADDR, rdv);
		chk(rdv, 8'h3F);
		$display("Test hard reset done");
		wr(16'hF090, 8'hC0);
		rd(ATA_SEL_ADDR, rdv);
		chk(rdv, 8'h3F);
		rd(16'hF090, rdv);
		chk(rdv, UNMAPPED_RDATA);
		clk_en = 1'b0;
		wr(FUNC_CFG_ADDR, 8'hAA);
		clk_en = 1'b1;
		rd(FUNC_CFG_ADDR, rdv);
		chk(rdv, 8'hFF);
		chk(func_obs, fexp(8'hFF));
		$display("Test unmapped and stall done");
		wr(FUNC_CFG_ADDR, 8'h44);
		chk(func_obs, fexp(8'h44));
		chk(iordy_res, 2'b10);
		ata_output_resistor_powerdown = 7'h40;
		repeat (2) @(negedge ref_clk);
		chk(ata_out_res, aexp(7'h3F, 7'h40));
		ata_output_resistor_powerdown = 7'h00;
		$display("Test firmware bring-up done");
		rst = 1'b1;
		@(negedge ref_clk);
		rst = 1'b0;
		@(negedge ref_clk);
		check_reset();
		$display("Test second reset done");
		close_out();
	end

	// Whole run is about 143 cycles; some twenty times that means a hang
	initial begin
		repeat (3000) @(posedge ref_clk);
		n_errors++;
		close_out();
	end

endmodule : pad_resistor_control_regs_tb_top
